// ===== inc/dpdi_pkg.sv
package dpdi_pkg;
  // ****************************************************
  // Data path sizes and codes
  // ****************************************************
  localparam int DATA_W = 10;
  localparam logic [9:0] CODE_FULL = 10'h3ff;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  // ****************************************************
  // Register port
  // ****************************************************
  localparam int ADDR_W = 4;
  localparam int REG_W = 16;
  localparam logic [3:0] ADDR_CFG = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h1;
  localparam logic [7:0] CFG_RST = 8'h24;
  localparam logic [15:0] RDATA_ZERO = 16'h0000;
  // ****************************************************
  // Lock detector and buffer
  // ****************************************************
  localparam int LOCK_W = 3;
  localparam logic [2:0] LOCK_GOOD = 3'h4;
  localparam logic [2:0] GAP_EXPECT = 3'h1;
  localparam logic [1:0] BUF_FULL = 2'h2;
  localparam logic [1:0] BUF_EMPTY = 2'h0;
  // Input mux selection per range select combination
  typedef enum logic [1:0] {
    DPDI_INTERLEAVE,
    DPDI_PORT1,
    DPDI_PORT2,
    DPDI_SPARE
  } dpdi_sel_e;
endpackage : dpdi_pkg

// ===== design/dpdi_top.sv
// Our own choices: the register offsets and the strobed register port.
module dpdi_top #(
  parameter logic [7:0] CFG_DEFAULT = dpdi_pkg::CFG_RST
) (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic MULT_SUPPLY_STRAP,
  input wire logic RANGE_SELECT_BIT0,
  input wire logic RANGE_SELECT_BIT1,
  input wire logic EXT_CLK,
  input wire logic RESET_IN,
  input wire logic [dpdi_pkg::DATA_W-1:0] PORT1_DATA,
  input wire logic [dpdi_pkg::DATA_W-1:0] PORT2_DATA,
  input wire logic [dpdi_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [dpdi_pkg::REG_W-1:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [dpdi_pkg::REG_W-1:0] REG_RDATA,
  output logic LOCK_OR_HALF_CLOCK_OUT,
  output logic [dpdi_pkg::DATA_W-1:0] TRUE_CODE_OUT,
  output logic [dpdi_pkg::DATA_W-1:0] COMPLEMENT_CODE_OUT,
  output logic OUT_VALID,
  input wire logic OUT_READY,
  output logic IN_READY
);
  import dpdi_pkg::*;

  // ****************************************************
  // Mode decode
  // ****************************************************
  function automatic dpdi_sel_e decode_sel(input logic [7:0] table_v, input logic [1:0] sel);
    dpdi_sel_e res;
    res = dpdi_sel_e'(table_v[{sel, 1'b0} +: 2]);
    if (res == DPDI_SPARE) begin
      res = DPDI_INTERLEAVE;
    end
    return res;
  endfunction : decode_sel

  logic [7:0] cfg_r;
  logic [1:0] sel;
  dpdi_sel_e mode;
  logic il;
  logic step;
  logic full;
  logic [1:0] cnt_r;

  assign sel = {RANGE_SELECT_BIT1, RANGE_SELECT_BIT0};
  assign mode = decode_sel(cfg_r, sel);
  assign il = MULT_SUPPLY_STRAP || (mode == DPDI_INTERLEAVE);
  assign full = (cnt_r == BUF_FULL);
  assign step = !full;

  // ****************************************************
  // External clock edge and lock detect
  // ****************************************************
  logic ext_clk_d_r;
  logic ext_rise;
  logic [LOCK_W-1:0] gap_r;
  logic [LOCK_W-1:0] good_r;
  logic lock_r;

  assign ext_rise = EXT_CLK && !ext_clk_d_r;

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      ext_clk_d_r <= 1'b0;
    end else begin
      ext_clk_d_r <= EXT_CLK;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      gap_r <= '0;
      good_r <= '0;
      lock_r <= 1'b0;
    end else if (ext_rise) begin
      gap_r <= '0;
      if (gap_r != GAP_EXPECT) begin
        good_r <= '0;
        lock_r <= 1'b0;
      end else if (good_r != LOCK_GOOD) begin
        good_r <= good_r + 3'h1;
      end else begin
        lock_r <= 1'b1;
      end
    end else if (gap_r != '1) begin
      gap_r <= gap_r + 3'h1;
    end
  end

  // ****************************************************
  // Half-rate clock and alignment
  // ****************************************************
  logic half_r;
  logic half_rise;

  assign half_rise = !MULT_SUPPLY_STRAP && !RESET_IN && step && !half_r;

  // reset forces 1, first edge after low with the buffer not full toggles
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      half_r <= 1'b1;
    end else if (MULT_SUPPLY_STRAP || RESET_IN) begin
      half_r <= 1'b1;
    end else if (step) begin
      half_r <= ~half_r;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      LOCK_OR_HALF_CLOCK_OUT <= 1'b0;
    end else begin
      LOCK_OR_HALF_CLOCK_OUT <= MULT_SUPPLY_STRAP ? lock_r : half_r;
    end
  end

  // ****************************************************
  // Input latches and output sequencing
  // ****************************************************
  logic [DATA_W-1:0] p1_r;
  logic [DATA_W-1:0] p2_r;
  logic pend_r;
  logic capture_ev;
  logic push;
  logic [DATA_W-1:0] push_data;

  assign capture_ev = MULT_SUPPLY_STRAP ? (ext_rise && step) : half_rise;
  assign push = capture_ev || (pend_r && step);

  always_comb begin
    push_data = p1_r;
    if (capture_ev) begin
      push_data = (il || mode == DPDI_PORT2) ? p2_r : p1_r;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      p1_r <= CODE_ZERO;
      p2_r <= CODE_ZERO;
    end else if (capture_ev) begin
      if (il || mode == DPDI_PORT1) begin
        p1_r <= PORT1_DATA;
      end
      if (il || mode == DPDI_PORT2) begin
        p2_r <= PORT2_DATA;
      end
    end
  end

  // second transfer one fast cycle later, or on the first cycle after that when the buffer is not full
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      pend_r <= 1'b0;
    end else if (capture_ev && il) begin
      pend_r <= 1'b1;
    end else if (step) begin
      pend_r <= 1'b0;
    end
  end

  // ****************************************************
  // Two-entry output buffer
  // ****************************************************
  logic [DATA_W-1:0] mem [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_nxt;
  logic pop;

  assign pop = (cnt_r != BUF_EMPTY) && (!OUT_VALID || OUT_READY);

  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= BUF_EMPTY;
      IN_READY <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      IN_READY <= (cnt_nxt != BUF_FULL);
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (push) begin
      mem[wp_r] <= push_data;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      OUT_VALID <= 1'b0;
      TRUE_CODE_OUT <= CODE_ZERO;
      COMPLEMENT_CODE_OUT <= CODE_FULL;
    end else if (pop) begin
      OUT_VALID <= 1'b1;
      TRUE_CODE_OUT <= mem[rp_r];
      COMPLEMENT_CODE_OUT <= CODE_FULL - mem[rp_r];
    end else if (OUT_READY) begin
      OUT_VALID <= 1'b0;
    end
  end

  // ****************************************************
  // Register port
  // ****************************************************
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_r <= CFG_DEFAULT;
    end else if (REG_WR && REG_ADDR == ADDR_CFG) begin
      cfg_r <= REG_WDATA[7:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= RDATA_ZERO;
    end else if (REG_RD && REG_ADDR == ADDR_CFG) begin
      REG_RDATA <= {8'h00, cfg_r};
    end else if (REG_RD && REG_ADDR == ADDR_STAT) begin
      REG_RDATA <= {8'h00, cnt_r, pend_r, lock_r, half_r, mode, MULT_SUPPLY_STRAP};
    end else begin
      REG_RDATA <= RDATA_ZERO;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  sequence s_capture_il;
    capture_ev && il;
  endsequence

  sequence s_reset_release;
    !MULT_SUPPLY_STRAP && RESET_IN ##1 !MULT_SUPPLY_STRAP && !RESET_IN && step;
  endsequence

  AST_ACTIVE_CAPTURE:
  assert property (MULT_SUPPLY_STRAP && ext_rise && step |=>
      p1_r == $past(PORT1_DATA) && p2_r == $past(PORT2_DATA))
    else $error("ports not captured on external rise");

  AST_PORT2_FIRST:
  assert property (s_capture_il |=> mem[$past(wp_r)] == $past(p2_r))
    else $error("port two value not sent first");

  AST_PORT1_SECOND:
  assert property (s_capture_il ##1 step |-> push && push_data == $past(PORT1_DATA))
    else $error("port one value not sent one cycle later");

  AST_FIXED_SPACING:
  assert property (s_capture_il |=> pend_r and (step |=> !pend_r))
    else $error("second transfer not one cycle after capture");

  AST_HALF_LATCH:
  assert property (half_rise && il |=> p1_r == $past(PORT1_DATA) && p2_r == $past(PORT2_DATA))
    else $error("latches not updated on half clock rise");

  AST_RESET_ALIGN:
  assert property (s_reset_release |=> !half_r ##1 (half_r || $past(!step)))
    else $error("half clock alignment after reset wrong");

  AST_RESET_HOLD:
  assert property (!MULT_SUPPLY_STRAP && RESET_IN |=> half_r)
    else $error("reset did not force half clock high");

  AST_LOCK_PIN_BYPASS:
  assert property (!MULT_SUPPLY_STRAP |=> LOCK_OR_HALF_CLOCK_OUT == $past(half_r))
    else $error("lock pin does not follow half clock");

  AST_LOCK_PIN_ACTIVE:
  assert property (MULT_SUPPLY_STRAP |=> LOCK_OR_HALF_CLOCK_OUT == $past(lock_r))
    else $error("lock pin does not show lock state");

  AST_SINGLE_PORT:
  assert property (capture_ev && !il && mode == DPDI_PORT1 |=>
      p1_r == $past(PORT1_DATA) && p2_r == $past(p2_r))
    else $error("unselected port latch changed");

  AST_COMPLEMENT:
  assert property (OUT_VALID |-> TRUE_CODE_OUT + COMPLEMENT_CODE_OUT == CODE_FULL)
    else $error("complement code wrong");

  AST_BUF_BOUND:
  assert property ((cnt_r <= BUF_FULL) and (full |-> !push))
    else $error("buffer overfilled");

  // Ready flag tracks fill level
  AST_IN_READY_LEVEL:
  assert property (IN_READY == (cnt_r != BUF_FULL))
    else $error("in ready does not match buffer level");

endmodule : dpdi_top

// ===== dv/dpdi_src_model.sv
// ****************************************************
// Data source model
// ****************************************************
module dpdi_src_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  output logic ext_clk,
  output logic [9:0] p1_data,
  output logic [9:0] p2_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] cnt_r;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_clk <= 1'b0;
    end else if (run) begin
      ext_clk <= ~ext_clk;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 9'h1f0;
    end else if (run && !ext_clk) begin
      cnt_r <= cnt_r + 9'h001;
    end
  end
  assign p1_data = {cnt_r, 1'b0};
  assign p2_data = {cnt_r, 1'b1};
endmodule : dpdi_src_model

// ===== dv/tb_dual_port_dac_input_interleaver.sv
module tb_dual_port_dac_input_interleaver;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic mult = 1'b1;
  logic sel0 = 1'b0;
  logic sel1 = 1'b0;
  logic rst_in = 1'b0;
  logic run = 1'b0;
  logic ext_clk;
  logic [9:0] p1;
  logic [9:0] p2;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata;
  logic pin;
  logic [9:0] true_out;
  logic [9:0] comp_out;
  logic out_valid;
  logic out_ready = 1'b1;
  logic in_ready;
  logic [9:0] words[$];
  int num_errors = 0;
  int num_checks = 0;
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  dpdi_src_model src (.clk(sys_clk), .rst_b(rst_b), .run(run), .ext_clk(ext_clk),
    .p1_data(p1), .p2_data(p2));
  dpdi_top dut (.SYS_CLK(sys_clk), .RST_B(rst_b), .MULT_SUPPLY_STRAP(mult),
    .RANGE_SELECT_BIT0(sel0), .RANGE_SELECT_BIT1(sel1), .EXT_CLK(ext_clk),
    .RESET_IN(rst_in), .PORT1_DATA(p1), .PORT2_DATA(p2), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .LOCK_OR_HALF_CLOCK_OUT(pin), .TRUE_CODE_OUT(true_out),
    .COMPLEMENT_CODE_OUT(comp_out), .OUT_VALID(out_valid), .OUT_READY(out_ready),
    .IN_READY(in_ready));
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task final_report;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : final_report
  // ****************************************************
  // Output monitor
  // ****************************************************
  always @(posedge sys_clk) begin
    if (out_valid === 1'b1 && out_ready) begin
      words.push_back(true_out);
      chk("complement", 16'(10'h3ff - true_out), 16'(comp_out));
    end
  end
  task reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : reg_wr
  task reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge sys_clk);
    #1 chk("rdata idle", 16'h0000, rdata);
  endtask : reg_rd
  task run_mode(input logic strap, input logic [1:0] sel, input logic [9:0] step, input int par);
    int i;
    @(posedge sys_clk);
    mult <= strap;
    sel0 <= sel[0];
    sel1 <= sel[1];
    run <= 1'b1;
    repeat (12) @(posedge sys_clk);
    words.delete();
    repeat (40) @(posedge sys_clk);
    chk("word count", 16'h0001, 16'(words.size() > 8));
    for (i = 1; i < words.size(); i++) begin
      chk("word step", 16'(step), 16'(10'(words[i] - words[i-1])));
      if (par >= 0) chk("word parity", 16'(par), 16'(words[i][0]));
    end
  endtask : run_mode
  task reg_scenario;
    logic [15:0] d;
    reg_rd(4'h0, d);
    chk("cfg reset", 16'h0024, d);
    reg_rd(4'h7, d);
    chk("unmapped read", 16'h0000, d);
    reg_rd(4'h1, d);
    chk("status reset", 16'h0009, d);
    reg_wr(4'h0, 16'h0018);
    reg_wr(4'h9, 16'h00ff);
    reg_rd(4'h0, d);
    chk("cfg written", 16'h0018, d);
  endtask : reg_scenario
  task stall_scenario;
    int n;
    logic [9:0] held;
    @(posedge sys_clk);
    out_ready <= 1'b0;
    for (n = 0; n < 50 && in_ready !== 1'b0; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("in_ready full", 16'h0000, 16'(in_ready));
    held = true_out;
    @(posedge sys_clk);
    run <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 chk("held word", 16'(held), 16'(true_out));
    chk("valid held", 16'h0001, 16'(out_valid));
    @(posedge sys_clk);
    out_ready <= 1'b1;
    for (n = 0; n < 20 && out_valid !== 1'b0; n++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("drained", 16'h0000, 16'(out_valid));
  endtask : stall_scenario
  task align_scenario;
    @(posedge sys_clk);
    rst_in <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk("half forced", 16'h0001, 16'(pin));
    @(posedge sys_clk);
    rst_in <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    #1 chk("half low", 16'h0000, 16'(pin));
    @(posedge sys_clk);
    #1 chk("half high", 16'h0001, 16'(pin));
  endtask : align_scenario
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 chk("reset true", 16'h0000, 16'(true_out));
    chk("reset comp", 16'h03ff, 16'(comp_out));
    chk("reset valid", 16'h0000, 16'(out_valid));
    chk("reset in_ready", 16'h0001, 16'(in_ready));
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    reg_scenario();
    run_mode(1'b0, 2'b01, 10'h002, 1);
    reg_wr(4'h0, 16'h0024);
    run_mode(1'b1, 2'b00, 10'h001, -1);
    #1 chk("lock pin", 16'h0001, 16'(pin));
    stall_scenario();
    run_mode(1'b0, 2'b00, 10'h001, -1);
    align_scenario();
    run_mode(1'b0, 2'b00, 10'h001, -1);
    run_mode(1'b0, 2'b01, 10'h002, 0);
    run_mode(1'b0, 2'b10, 10'h002, 1);
    run_mode(1'b0, 2'b11, 10'h001, -1);
    reg_wr(4'h0, 16'h00e4);
    run_mode(1'b0, 2'b11, 10'h001, -1);
    final_report();
  end
endmodule : tb_dual_port_dac_input_interleaver
